/* logic/bst_defs.svh */
// Constants for the boundary-scan test access port: codes, capture values and reset values.
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// Instruction register width and the codes that the port decodes.
`define BST_IR_W          10
`define BST_IR_SAMPLE     10'h005
`define BST_IR_EXTEST     10'h00f
`define BST_IR_BYPASS     10'h3ff

// Pattern loaded in Capture-IR; the low bit leaves first, so a one then a zero.
`define BST_IR_CAPTURE    10'h001

// Depth of every two-flop synchroniser.
`define BST_SYNC_STAGES   2

// Update latch values after reset: pin released, data low.
`define BST_OE_LATCH_RST  1'h1
`define BST_OUT_LATCH_RST 1'h0

`endif

/* logic/bst_pkg.sv */
// Types shared by the boundary-scan test access port.
package bst_pkg;

    // Controller states, one-hot.
    typedef enum logic [15:0] {
        TLR        = 16'h0001,
        RUN_IDLE   = 16'h0002,
        SEL_DR     = 16'h0004,
        CAPTURE_DR = 16'h0008,
        SHIFT_DR   = 16'h0010,
        EXIT1_DR   = 16'h0020,
        PAUSE_DR   = 16'h0040,
        EXIT2_DR   = 16'h0080,
        UPDATE_DR  = 16'h0100,
        SEL_IR     = 16'h0200,
        CAPTURE_IR = 16'h0400,
        SHIFT_IR   = 16'h0800,
        EXIT1_IR   = 16'h1000,
        PAUSE_IR   = 16'h2000,
        EXIT2_IR   = 16'h4000,
        UPDATE_IR  = 16'h8000
    } bst_state_type;

endpackage : bst_pkg

/* logic/bst_cell.sv */
// One pin's boundary-scan cells: input, output data and output enable, with update latches.
`timescale 1ns/1ps
`include "bst_defs.svh"

module bst_cell (
    // Test clock and reset.
    input  wire logic tck,
    input  wire logic rst_n,
    // Controls from the controller.
    input  wire logic capture,
    input  wire logic shift,
    input  wire logic update,
    // Serial chain.
    input  wire logic si,
    output logic      so,
    // Values captured from the pin and from the core.
    input  wire logic cap_in,
    input  wire logic cap_out,
    input  wire logic cap_oe_n,
    // Update latches that steer the pin in external test.
    output logic      output_data_update_latch,
    output logic      output_enable_update_latch
);

    // Shift stages: [2] enable cell nearest the input, [0] input cell nearest the output.
    logic [2:0] stage;

    assign so = stage[0];

    // Capture snapshots the pin; shift moves one place toward the output end.
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            stage <= 3'h0;
        end else if (capture) begin
            stage <= {cap_oe_n, cap_out, cap_in};
        end else if (shift) begin
            stage <= {si, stage[2:1]};
        end
    end

    // Latches only change on update, so shifting never disturbs driven pins.
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            output_enable_update_latch <= `BST_OE_LATCH_RST;
            output_data_update_latch   <= `BST_OUT_LATCH_RST;
        end else if (update) begin
            output_enable_update_latch <= stage[2];
            output_data_update_latch   <= stage[1];
        end
    end

endmodule : bst_cell

/* logic/bst_tap.sv */
// Boundary-scan test access port: controller, instruction and data registers, pin steering.
`timescale 1ns/1ps
`include "bst_defs.svh"

module bst_tap #(
    parameter int NPINS = 4
) (
    // System clock and reset.
    input  wire logic             clk,
    input  wire logic             nrst,
    // Test link, clocked by the tester.
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo,
    output logic                  tdo_oe_n,
    // Configuration start pin, active low.
    input  wire logic             config_start_n,
    // Core side of the pins.
    input  wire logic [NPINS-1:0] core_out,
    input  wire logic [NPINS-1:0] core_oe_n,
    // Pad side of the pins.
    input  wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0]      pin_out,
    output logic [NPINS-1:0]      pin_oe_n
);

    bst_pkg::bst_state_type state;
    bst_pkg::bst_state_type next_state;

    logic [1:0]           tck_rst_sync;
    logic                 tck_rst_n;
    logic [`BST_IR_W-1:0] ir_shift;
    logic [`BST_IR_W-1:0] ir;
    logic                 bypass_bit;
    logic                 extest_mode;
    logic [NPINS-1:0]     pin_in_m, pin_in_s;
    logic [NPINS-1:0]     core_out_m, core_out_s;
    logic [NPINS-1:0]     core_oe_m, core_oe_s;
    logic [NPINS:0]       chain;
    logic [NPINS-1:0]     out_latch, oe_latch_n;
    logic [NPINS-1:0]     out_m, out_s, oe_m, oe_s;
    logic                 ext_m, ext_s, cfg_m, cfg_s;

    // Reset of the test domain: asserts at once, releases on the second test clock edge.
    always_ff @(posedge tck or negedge nrst) begin
        if (!nrst) begin
            tck_rst_sync <= 2'h0;
        end else begin
            tck_rst_sync <= {tck_rst_sync[0], 1'h1};
        end
    end
    assign tck_rst_n = tck_rst_sync[1];

    // Controller transitions on the mode input.
    always_comb begin
        case (state)
            bst_pkg::TLR:        next_state = tms ? bst_pkg::TLR : bst_pkg::RUN_IDLE;
            bst_pkg::RUN_IDLE:   next_state = tms ? bst_pkg::SEL_DR : bst_pkg::RUN_IDLE;
            bst_pkg::SEL_DR:     next_state = tms ? bst_pkg::SEL_IR : bst_pkg::CAPTURE_DR;
            bst_pkg::CAPTURE_DR: next_state = tms ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
            bst_pkg::SHIFT_DR:   next_state = tms ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
            bst_pkg::EXIT1_DR:   next_state = tms ? bst_pkg::UPDATE_DR : bst_pkg::PAUSE_DR;
            bst_pkg::PAUSE_DR:   next_state = tms ? bst_pkg::EXIT2_DR : bst_pkg::PAUSE_DR;
            bst_pkg::EXIT2_DR:   next_state = tms ? bst_pkg::UPDATE_DR : bst_pkg::SHIFT_DR;
            bst_pkg::UPDATE_DR:  next_state = tms ? bst_pkg::SEL_DR : bst_pkg::RUN_IDLE;
            bst_pkg::SEL_IR:     next_state = tms ? bst_pkg::TLR : bst_pkg::CAPTURE_IR;
            bst_pkg::CAPTURE_IR: next_state = tms ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
            bst_pkg::SHIFT_IR:   next_state = tms ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
            bst_pkg::EXIT1_IR:   next_state = tms ? bst_pkg::UPDATE_IR : bst_pkg::PAUSE_IR;
            bst_pkg::PAUSE_IR:   next_state = tms ? bst_pkg::EXIT2_IR : bst_pkg::PAUSE_IR;
            bst_pkg::EXIT2_IR:   next_state = tms ? bst_pkg::UPDATE_IR : bst_pkg::SHIFT_IR;
            bst_pkg::UPDATE_IR:  next_state = tms ? bst_pkg::SEL_DR : bst_pkg::RUN_IDLE;
            default:             next_state = bst_pkg::TLR;
        endcase
    end

    // The controller needs no command to start; reset alone puts it in Test-Logic-Reset.
    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            state <= bst_pkg::TLR;
        end else begin
            state <= next_state;
        end
    end

    // State and instruction decode.
    wire in_tlr      = (state == bst_pkg::TLR);
    wire in_cap_ir   = (state == bst_pkg::CAPTURE_IR);
    wire in_shift_ir = (state == bst_pkg::SHIFT_IR);
    wire in_upd_ir   = (state == bst_pkg::UPDATE_IR);
    wire in_cap_dr   = (state == bst_pkg::CAPTURE_DR);
    wire in_shift_dr = (state == bst_pkg::SHIFT_DR);
    wire in_upd_dr   = (state == bst_pkg::UPDATE_DR);
    wire sel_sample  = (ir == `BST_IR_SAMPLE);
    wire sel_extest  = (ir == `BST_IR_EXTEST);
    // Any code without a register of its own, including all-ones, selects the bypass bit.
    wire sel_bypass  = !(sel_sample || sel_extest);
    wire dr_capture  = in_cap_dr && !sel_bypass;
    wire dr_shift    = in_shift_dr && !sel_bypass;
    wire dr_update   = in_upd_dr && !sel_bypass;
    wire load_extest = (ir_shift == `BST_IR_EXTEST);

    // Instruction shift register: loads the one-zero pattern on capture.
    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            ir_shift <= `BST_IR_CAPTURE;
        end else if (in_cap_ir) begin
            ir_shift <= `BST_IR_CAPTURE;
        end else if (in_shift_ir) begin
            ir_shift <= {tdi, ir_shift[`BST_IR_W-1:1]};
        end
    end

    // Active instruction; Test-Logic-Reset falls back to bypass so pins return to the core.
    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            ir <= `BST_IR_BYPASS;
        end else if (in_tlr) begin
            ir <= `BST_IR_BYPASS;
        end else if (in_upd_ir) begin
            ir <= ir_shift;
        end
    end

    // One-bit bypass register, cleared on capture.
    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            bypass_bit <= 1'h0;
        end else if (in_cap_dr) begin
            bypass_bit <= 1'h0;
        end else if (in_shift_dr) begin
            bypass_bit <= tdi;
        end
    end

    // Mode loads with the instruction, so it holds even when the link clock stops after Update-IR.
    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            extest_mode <= 1'h0;
        end else if (in_tlr) begin
            extest_mode <= 1'h0;
        end else if (in_upd_ir) begin
            extest_mode <= load_extest;
        end
    end

    // Pin and core levels come from other domains; two flops before capture.
    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            pin_in_m   <= '0;
            pin_in_s   <= '0;
            core_out_m <= '0;
            core_out_s <= '0;
            core_oe_m  <= '1;
            core_oe_s  <= '1;
        end else begin
            pin_in_m   <= pin_in;
            pin_in_s   <= pin_in_m;
            core_out_m <= core_out;
            core_out_s <= core_out_m;
            core_oe_m  <= core_oe_n;
            core_oe_s  <= core_oe_m;
        end
    end

    // Boundary register: data enters at the top pin and leaves from pin 0's input cell.
    assign chain[NPINS] = tdi;
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        bst_cell u_cell (
            .tck                        (tck),
            .rst_n                      (tck_rst_n),
            .capture                    (dr_capture),
            .shift                      (dr_shift),
            .update                     (dr_update),
            .si                         (chain[i+1]),
            .so                         (chain[i]),
            .cap_in                     (pin_in_s[i]),
            .cap_out                    (core_out_s[i]),
            .cap_oe_n                   (core_oe_s[i]),
            .output_data_update_latch   (out_latch[i]),
            .output_enable_update_latch (oe_latch_n[i])
        );
    end

    // Data out changes on the falling edge and is released outside the shift states.
    wire tdo_next = in_shift_ir ? ir_shift[0] : (sel_bypass ? bypass_bit : chain[0]);
    always_ff @(negedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            tdo      <= 1'h0;
            tdo_oe_n <= 1'h1;
        end else begin
            tdo      <= tdo_next;
            tdo_oe_n <= !(in_shift_ir || in_shift_dr);
        end
    end

    // Latches and mode cross to the system clock as levels; a test pattern reaches the pins on the third edge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_m <= '0;
            out_s <= '0;
            oe_m  <= '1;
            oe_s  <= '1;
            ext_m <= 1'h0;
            ext_s <= 1'h0;
            cfg_m <= 1'h0;
            cfg_s <= 1'h0;
        end else begin
            out_m <= out_latch;
            out_s <= out_m;
            oe_m  <= oe_latch_n;
            oe_s  <= oe_m;
            ext_m <= extest_mode;
            ext_s <= ext_m;
            cfg_m <= config_start_n;
            cfg_s <= cfg_m;
        end
    end

    // While configuration start is low the core is unconfigured and leaves its pins released.
    wire [NPINS-1:0] core_oe_gated = cfg_s ? core_oe_n : {NPINS{1'b1}};
    wire [NPINS-1:0] next_pin_out  = ext_s ? out_s : core_out;
    wire [NPINS-1:0] next_pin_oe_n = ext_s ? oe_s : core_oe_gated;

    // Registered pad drive.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_out  <= '0;
            pin_oe_n <= '1;
        end else begin
            pin_out  <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
        end
    end

    // Checks on the test-clock side.
    sequence s_enter_shift_ir;
        in_tlr && !tms ##1 tms ##1 tms ##1 !tms ##1 !tms;
    endsequence

    sequence s_first_ir_shift;
        in_cap_ir && !tms;
    endsequence

    property p_ir_pattern;
        @(posedge tck) disable iff (!tck_rst_n)
        s_first_ir_shift |=> (tdo == 1'b1) && !tdo_oe_n ##1 (!in_shift_ir || tdo == 1'b0);
    endproperty
    a_ir_pattern: assert property (p_ir_pattern) else $error("capture pattern not 1 then 0");
    property p_walk;
        @(posedge tck) disable iff (!tck_rst_n)
        s_enter_shift_ir |=> in_shift_ir;
    endproperty
    a_walk: assert property (p_walk) else $error("01100 did not reach Shift-IR");
    property p_power_up;
        @(posedge tck) disable iff (!tck_rst_n)
        $rose(tck_rst_n) |-> in_tlr && (ir == `BST_IR_BYPASS);
    endproperty
    a_power_up: assert property (p_power_up) else $error("not in reset state after power-up");
    property p_sample_capture;
        @(posedge tck) disable iff (!tck_rst_n)
        in_cap_dr && sel_sample && !tms |=> !tdo_oe_n && (tdo == $past(pin_in_s[0]));
    endproperty
    a_sample_capture: assert property (p_sample_capture) else $error("pin not sampled");
    property p_extest_mode;
        @(posedge tck) disable iff (!tck_rst_n)
        in_upd_ir |=> extest_mode == ($past(ir_shift) == `BST_IR_EXTEST);
    endproperty
    a_extest_mode: assert property (p_extest_mode) else $error("external test not active");
    property p_bypass;
        @(posedge tck) disable iff (!tck_rst_n)
        in_shift_dr && sel_bypass ##1 in_shift_dr |-> tdo == $past(tdi);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass delay not one cycle");
    property p_tdo_release;
        @(posedge tck) disable iff (!tck_rst_n)
        !(in_shift_ir || in_shift_dr) |-> tdo_oe_n;
    endproperty
    a_tdo_release: assert property (p_tdo_release) else $error("data out driven outside shift");
    // Check on the system-clock side.
    property p_extest_drive;
        @(posedge clk) disable iff (!nrst)
        ext_s |=> (pin_oe_n == $past(oe_s)) && (((pin_out ^ $past(out_s)) & ~pin_oe_n) == '0);
    endproperty
    a_extest_drive: assert property (p_extest_drive) else $error("pin not from latch");

endmodule : bst_tap

/* dv/bst_tester.sv */
// Behavioural boundary-scan tester that clocks the test link and scans registers.
`timescale 1ns/1ps

module bst_tester (
    // Test link driven by the tester.
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    // Answer from the device.
    input  wire logic tdo,
    input  wire logic tdo_oe_n
);
    // Answer sampled during the last link cycle.
    logic so;
    logic so_oe_n;

    // The link clock stands still low between frames.
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
    end

    // One 64 ns link cycle; the answer is sampled just before the rising edge,
    // after standing for half a period, so no race with the falling-edge update.
    task automatic pulse(input logic m, input logic d);
        #1;
        tms = m;
        tdi = d;
        #31;
        so = tdo;
        so_oe_n = tdo_oe_n;
        tck = 1'h1;
        #32;
        tck = 1'h0;
    endtask : pulse

    // Idle cycles with mode high; data toggles so a stale level is never trusted.
    task automatic idle(input int n);
        repeat (n) pulse(1'h1, ~tdi);
    endtask : idle

    // Five mode-high cycles reach Test-Logic-Reset, then one low cycle to Run-Idle.
    task automatic reset_tap();
        idle(5);
        pulse(1'h0, ~tdi);
    endtask : reset_tap

    // Scan n bits low bit first from Run-Idle back to Run-Idle; bad flags a shift cycle,
    // the Select cycle before Capture or the Exit1 cycle where the output enable is wrong.
    task automatic scan(input logic ir, input int n, input logic [15:0] din,
                        output logic [15:0] dout, output logic bad);
        dout = '0;
        pulse(1'h1, ~tdi);
        if (ir) pulse(1'h1, ~tdi);
        pulse(1'h0, ~tdi);
        bad = (so_oe_n !== 1'h1);
        pulse(1'h0, ~tdi);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i]);
            dout[i] = so;
            bad = bad | (so_oe_n !== 1'h0);
        end
        pulse(1'h1, ~tdi);
        bad = bad | (so_oe_n !== 1'h1);
        pulse(1'h0, ~tdi);
    endtask : scan
endmodule : bst_tester

/* dv/bst_tap_tb.sv */
// Self-checking testbench for the boundary-scan test access port.
`timescale 1ns/1ps
`include "bst_defs.svh"

module bst_tap_tb;
    localparam int NP = 4;

    // Clock, reset and pins.
    logic          clk;
    logic          nrst;
    logic          tck;
    logic          tms;
    logic          tdi;
    logic          tdo;
    logic          tdo_oe_n;
    logic          config_start_n;
    logic [NP-1:0] core_out;
    logic [NP-1:0] core_oe_n;
    logic [NP-1:0] pin_in;
    logic [NP-1:0] pin_out;
    logic [NP-1:0] pin_oe_n;
    logic [15:0]   got;
    logic          bad;
    int            miscompares;
    int            n_tests;

    bst_tap #(.NPINS(NP)) dut_u (
        .clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .config_start_n(config_start_n), .core_out(core_out),
        .core_oe_n(core_oe_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
    );

    // A released data out shows the inverse of its last level, so a stale bit is never trusted.
    bst_tester tst_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe_n ? ~tdo : tdo),
                      .tdo_oe_n(tdo_oe_n));

    // System clock, 25 ns.
    initial clk = 1'h0;
    always #12.5 clk = ~clk;

    // Compare one value and count it.
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    // Boundary vector as the chain holds it: input, data, enable for each pin.
    function automatic logic [15:0] bvec(input logic [3:0] a, input logic [3:0] b,
                                         input logic [3:0] c);
        bvec = '0;
        for (int p = 0; p < NP; p++) begin
            bvec[3*p] = a[p];
            bvec[3*p+1] = b[p];
            bvec[3*p+2] = c[p];
        end
    endfunction : bvec

    // Drive configuration, core and pad inputs on a clock edge, then give the syncs time to land.
    task automatic set_pins(input logic cs, input logic [3:0] co, input logic [3:0] ce,
                            input logic [3:0] pi);
        @(posedge clk);
        config_start_n <= cs;
        core_out <= co;
        core_oe_n <= ce;
        pin_in <= pi;
        repeat (8) @(posedge clk);
        #1;
    endtask : set_pins

    // Power-up: no enable step, straight to Shift-IR and a bypass load.
    task automatic t_reset();
        chk(tdo_oe_n, 1'h1, "tdo driven while idle");
        chk(pin_out, core_out, "normal mode pins");
        tst_u.reset_tap();
        tst_u.scan(1'h1, 10, 16'h03ff, got, bad);
        chk(got[1:0], 2'h1, "ir capture pattern");
        chk(bad, 1'h0, "tdo enable in ir scan");
    endtask : t_reset

    // Bypass: the bypass code and an unsupported one both give one cycle of delay.
    task automatic t_bypass();
        logic [9:0] codes [2];
        codes = '{`BST_IR_BYPASS, 10'h0aa};
        foreach (codes[k]) begin
            tst_u.scan(1'h1, 10, {6'h00, codes[k]}, got, bad);
            tst_u.scan(1'h0, 8, 16'h00b4, got, bad);
            chk(got[7:1], 7'h34, "bypass delay");
            chk(got[0], 1'h0, "bypass cleared on capture");
            chk(bad, 1'h0, "tdo enable in dr scan");
        end
    endtask : t_bypass

    // Sample/preload: snapshot of pins, preload latches, pins stay with the core.
    task automatic t_sample();
        tst_u.scan(1'h1, 10, {6'h00, `BST_IR_SAMPLE}, got, bad);
        tst_u.scan(1'h0, 12, bvec(4'h0, 4'h6, 4'ha), got, bad);
        chk(got, bvec(4'ha, 4'h5, 4'h3), "sample capture");
        repeat (8) @(posedge clk);
        #1;
        chk(pin_out, 4'h5, "sample keeps core data");
        chk(pin_oe_n, 4'h3, "sample keeps core enable");
        set_pins(1'h0, 4'h5, 4'h3, 4'h9);
        chk(pin_oe_n, 4'hf, "unconfigured pins released");
    endtask : t_sample

    // External test: latches drive pins, inputs are captured, reset hands back.
    task automatic t_extest();
        tst_u.scan(1'h1, 10, {6'h00, `BST_IR_EXTEST}, got, bad);
        repeat (8) @(posedge clk);
        #1;
        chk(pin_oe_n, 4'ha, "extest enable from latch");
        chk(pin_out, 4'h6, "extest data from latch");
        tst_u.scan(1'h0, 12, bvec(4'h0, 4'h9, 4'h5), got, bad);
        chk(got, bvec(4'h9, 4'h5, 4'h3), "extest capture");
        repeat (8) @(posedge clk);
        #1;
        chk(pin_oe_n, 4'h5, "extest new enable");
        chk(pin_out, 4'h9, "extest new data");
        tst_u.idle(5);
        repeat (8) @(posedge clk);
        #1;
        chk(pin_oe_n, 4'hf, "reset returns pins");
        set_pins(1'h1, 4'hc, 4'h0, 4'h9);
        chk(pin_out, 4'hc, "core drives again");
        chk(pin_oe_n, 4'h0, "core enables again");
    endtask : t_extest

    // Verdict and end of run.
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // Watchdog: the tests need about 11 us.
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end

    // Reset for four clocks with one link cycle inside, then the scenarios.
    initial begin
        miscompares = 0;
        n_tests = 0;
        nrst = 1'h0;
        config_start_n = 1'h1;
        core_out = 4'h5;
        core_oe_n = 4'h3;
        pin_in = 4'ha;
        fork
            repeat (4) @(posedge clk);
            tst_u.idle(1);
        join
        nrst <= 1'h1;
        repeat (8) @(posedge clk);
        #1;
        t_reset();
        t_bypass();
        t_sample();
        t_extest();
        print_verdict();
    end
endmodule : bst_tap_tb
